// ---- logic/prs_pkg.sv ----
// Constants, field layouts and carrier types of the power resource sequencer.
// Assumes one 200 MHz register clock; the slow sequencer tick is derived from it.
`default_nettype none
package prs_pkg;
  // Clocking: register clock and the slow sequencer tick rate
  localparam int unsigned PRS_CLK_HZ = 200_000_000;
  localparam int unsigned PRS_TICK_HZ = 32_768;
  localparam int unsigned PRS_TICK_CYCLES = PRS_CLK_HZ / PRS_TICK_HZ;
  // Default sizes
  localparam int unsigned PRS_NRES = 8;
  localparam int unsigned PRS_TW = 8;
  localparam int unsigned PRS_NCLK = 4;
  localparam int unsigned PRS_RTW = 16;
  // Register byte offsets
  localparam logic [11:0] PRS_MIN_OFS = 12'h000;
  localparam logic [11:0] PRS_RTMR_OFS = 12'h004;
  localparam logic [11:0] PRS_STATE_OFS = 12'h008;
  localparam logic [11:0] PRS_TRANSIT_OFS = 12'h00c;
  localparam logic [11:0] PRS_REGCTL_OFS = 12'h010;
  localparam logic [11:0] PRS_REGSTAT_OFS = 12'h014;
  localparam logic [11:0] PRS_TIME_OFS = 12'h020;
  // Field positions
  localparam int unsigned PRS_RTMASK_LSB = 0;
  localparam int unsigned PRS_RTCNT_LSB = 16;
  localparam int unsigned PRS_TON_LSB = 0;
  localparam int unsigned PRS_TOFF_LSB = 16;
  localparam int unsigned PRS_DEM_QUIET1 = 0;
  localparam int unsigned PRS_DEM_QUIET2 = 1;
  localparam int unsigned PRS_DEM_AMP = 2;
  localparam int unsigned PRS_DEM_W = 3;
  // Reset values
  localparam logic [31:0] PRS_MIN_RST = 32'h0000_0001;
  localparam logic [15:0] PRS_TON_RST = 16'h0002;
  localparam logic [15:0] PRS_TOFF_RST = 16'h0001;
  // Default tables: resource i depends on i-1; clock k needs resources 0..k
  localparam logic [63:0] PRS_DEP_DFLT = 64'h4020_1008_0402_0100;
  localparam logic [31:0] PRS_CLKMAP_DFLT = 32'h0f07_0301;

  typedef enum logic [3:0] {
    PRS_OFF = 4'b0001,
    PRS_ON = 4'b0010,
    PRS_RAMP_UP = 4'b0100,
    PRS_RAMP_DN = 4'b1000
  } prs_phase_type;

  typedef struct packed {
    logic core_switching_regulator;
    logic core_linear_regulator;
    logic quiet_regulator_one;
    logic quiet_regulator_two;
    logic amplifier_regulator;
  } prs_reg_en_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } prs_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } prs_apb_rsp_type;
endpackage
`default_nettype wire

// ---- logic/prs_sequencer.sv ----
// Power resource sequencer: request merge, dependency closure, per-resource
// ramp timers, regulator enables and shutdown handling, with an APB slave.
// Assumes clock requests come from logic on pclk; the two power request pins
// are asynchronous and are synchronised here.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module prs_sequencer #(
  parameter int unsigned NRES = prs_pkg::PRS_NRES,
  parameter int unsigned TW = prs_pkg::PRS_TW,
  parameter int unsigned NCLK = prs_pkg::PRS_NCLK,
  parameter int unsigned TICK_DIV = prs_pkg::PRS_TICK_CYCLES,
  parameter logic [NRES*NRES-1:0] DEP = prs_pkg::PRS_DEP_DFLT[NRES*NRES-1:0],
  parameter logic [NCLK*NRES-1:0] CLK_MAP = prs_pkg::PRS_CLKMAP_DFLT[NCLK*NRES-1:0]
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire prs_pkg::prs_apb_req_type apb_req,
  output var prs_pkg::prs_apb_rsp_type apb_rsp,
  // Requests
  input wire logic [NCLK-1:0] clock_request,
  input wire logic radio_a_power_request,
  input wire logic radio_b_power_request,
  // Power outputs
  output var prs_pkg::prs_reg_en_type regulator_enable,
  output logic [NRES-1:0] resource_on_bit,
  output logic [NRES-1:0] resource_in_transit_bit,
  output logic io_output_enable
);
  import prs_pkg::*;

  localparam int unsigned DW = $clog2(TICK_DIV);

  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [DW-1:0] div;
    logic tick;
    prs_phase_type [NRES-1:0] phase;
    logic [NRES-1:0][TW-1:0] timer;
    logic [NRES-1:0][TW-1:0] t_on;
    logic [NRES-1:0][TW-1:0] t_off;
    logic [NRES-1:0] min_mask;
    logic [NRES-1:0] rt_mask;
    logic [PRS_RTW-1:0] rt_count;
    logic [PRS_DEM_W-1:0] demand;
    prs_reg_en_type reg_en;
    logic io_enable;
    logic [NRES-1:0] on_bits;
    logic [NRES-1:0] transit_bits;
    prs_apb_rsp_type rsp;
  } prs_state_type;

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic prs_state_type init_state();
    prs_state_type s;
    s = '0;
    for (int i = 0; i < NRES; i++) begin
      s.phase[i] = PRS_OFF;
      s.t_on[i] = PRS_TON_RST[TW-1:0];
      s.t_off[i] = PRS_TOFF_RST[TW-1:0];
    end
    s.min_mask = PRS_MIN_RST[NRES-1:0];
    return s;
  endfunction

  localparam prs_state_type ST_RST = init_state();

  // Adds every resource that a requested one depends on, transitively
  function automatic logic [NRES-1:0] close_deps(input logic [NRES-1:0] r);
    logic [NRES-1:0] c;
    c = r;
    for (int p = 0; p < NRES; p++) begin
      for (int i = 0; i < NRES; i++) begin
        if (c[i]) begin
          c = c | DEP[i*NRES +: NRES];
        end
      end
    end
    return c;
  endfunction

  // Decodes a per-resource time register address; bit 8 flags a hit
  function automatic logic [8:0] time_sel(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - PRS_TIME_OFS;
    time_sel = {1'b0, rel[9:2]};
    if (a >= PRS_TIME_OFS && a[1:0] == 2'b00 && rel[11:2] < 10'(NRES)) begin
      time_sel[8] = 1'b1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  prs_state_type st_q;
  prs_state_type st_d;
  logic shutdown;
  logic [NRES-1:0] need;
  logic [NRES-1:0] go_on;
  logic [NRES-1:0] go_off;

  always_comb begin
    prs_state_type nx;
    prs_state_type rs;
    logic [NRES-1:0] req;
    logic [NRES-1:0] is_on;
    logic [NRES-1:0] powered;
    logic blocked;
    logic hit;
    logic [8:0] ts;
    logic [31:0] rd;
    nx = st_q;
    rs = ST_RST;
    req = '0;
    is_on = '0;
    powered = '0;
    blocked = 1'b0;
    ts = time_sel(apb_req.paddr);
    hit = 1'b1;
    rd = '0;
    go_on = '0;
    go_off = '0;
    nx.sync_a = {st_q.sync_a[0], radio_a_power_request};
    nx.sync_b = {st_q.sync_b[0], radio_b_power_request};
    // Both requests at their reset level means the chip is shut down
    shutdown = !st_q.sync_a[1] && !st_q.sync_b[1];

    // Slow tick divider
    nx.tick = 1'b0;
    if (st_q.div == DW'(TICK_DIV - 1)) begin
      nx.div = '0;
      nx.tick = 1'b1;
    end else begin
      nx.div = st_q.div + 1'b1;
    end

    // Required set
    for (int k = 0; k < NCLK; k++) begin
      if (clock_request[k]) begin
        req = req | CLK_MAP[k*NRES +: NRES];
      end
    end
    req = req | st_q.min_mask | ((st_q.rt_count != '0) ? st_q.rt_mask : '0);
    need = close_deps(req);

    if (st_q.tick) begin
      if (st_q.rt_count != '0) begin
        nx.rt_count = st_q.rt_count - 1'b1;
      end
      for (int i = 0; i < NRES; i++) begin
        if (st_q.timer[i] != '0) begin
          nx.timer[i] = st_q.timer[i] - 1'b1;
          if (st_q.timer[i] == TW'(1)) begin
            nx.phase[i] = (st_q.phase[i] == PRS_RAMP_UP) ? PRS_ON : PRS_OFF;
          end
        end
      end
      for (int i = 0; i < NRES; i++) begin
        is_on[i] = (nx.phase[i] == PRS_ON);
        powered[i] = (nx.phase[i] != PRS_OFF);
      end
      for (int i = 0; i < NRES; i++) begin
        blocked = 1'b0;
        for (int j = 0; j < NRES; j++) begin
          if (DEP[j*NRES + i] && powered[j]) begin
            blocked = 1'b1;
          end
        end
        go_off[i] = is_on[i] && !need[i] && !blocked;
        go_on[i] = (nx.phase[i] == PRS_OFF) && need[i]
          && ((DEP[i*NRES +: NRES] & ~is_on) == '0);
        if (go_off[i]) begin
          if (st_q.t_off[i] == '0) begin
            nx.phase[i] = PRS_OFF;
          end else begin
            nx.phase[i] = PRS_RAMP_DN;
            nx.timer[i] = st_q.t_off[i];
          end
        end else if (go_on[i]) begin
          if (st_q.t_on[i] == '0) begin
            nx.phase[i] = PRS_ON;
          end else begin
            nx.phase[i] = PRS_RAMP_UP;
            nx.timer[i] = st_q.t_on[i];
          end
        end
      end
    end

    // Core regulators and IO drivers on; quiet and amplifier regulators follow the demand register
    nx.reg_en.core_switching_regulator = 1'b1;
    nx.reg_en.core_linear_regulator = 1'b1;
    nx.reg_en.quiet_regulator_one = st_q.demand[PRS_DEM_QUIET1];
    nx.reg_en.quiet_regulator_two = st_q.demand[PRS_DEM_QUIET2];
    nx.reg_en.amplifier_regulator = st_q.demand[PRS_DEM_AMP];
    nx.io_enable = 1'b1;

    // Shutdown wipes all state but the synchronisers and the bus response, as a power-up would
    if (shutdown) begin
      rs.sync_a = nx.sync_a;
      rs.sync_b = nx.sync_b;
      rs.rsp = st_q.rsp;
      nx = rs;
    end

    for (int i = 0; i < NRES; i++) begin
      nx.on_bits[i] = (nx.phase[i] == PRS_ON) || (nx.phase[i] == PRS_RAMP_DN);
      nx.transit_bits[i] = (nx.phase[i] == PRS_RAMP_UP) || (nx.phase[i] == PRS_RAMP_DN);
    end

    // APB slave: one wait state, then ready with registered data
    unique case (apb_req.paddr)
      PRS_MIN_OFS: rd = 32'(st_q.min_mask);
      PRS_RTMR_OFS: rd = (32'(st_q.rt_mask) << PRS_RTMASK_LSB)
        | (32'(st_q.rt_count) << PRS_RTCNT_LSB);
      PRS_STATE_OFS: rd = 32'(st_q.on_bits);
      PRS_TRANSIT_OFS: rd = 32'(st_q.transit_bits);
      PRS_REGCTL_OFS: rd = 32'(st_q.demand);
      PRS_REGSTAT_OFS: rd = 32'(st_q.reg_en);
      default: begin
        hit = ts[8];
        if (ts[8]) begin
          rd = (32'(st_q.t_on[ts[7:0]]) << PRS_TON_LSB)
            | (32'(st_q.t_off[ts[7:0]]) << PRS_TOFF_LSB);
        end
      end
    endcase
    nx.rsp.pready = 1'b0;
    if (apb_req.psel && apb_req.penable && !st_q.rsp.pready) begin
      nx.rsp.pready = 1'b1;
      nx.rsp.prdata = apb_req.pwrite ? '0 : rd;
      nx.rsp.pslverr = !hit;
    end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && hit) begin
      // Write takes effect on the edge where pready is seen high
      unique case (apb_req.paddr)
        PRS_MIN_OFS: nx.min_mask = apb_req.pwdata[NRES-1:0];
        PRS_RTMR_OFS: begin
          nx.rt_mask = apb_req.pwdata[PRS_RTMASK_LSB +: NRES];
          nx.rt_count = apb_req.pwdata[PRS_RTCNT_LSB +: PRS_RTW];
        end
        PRS_REGCTL_OFS: nx.demand = apb_req.pwdata[PRS_DEM_W-1:0];
        PRS_STATE_OFS, PRS_TRANSIT_OFS, PRS_REGSTAT_OFS: ;
        default: begin
          nx.t_on[ts[7:0]] = apb_req.pwdata[PRS_TON_LSB +: TW];
          nx.t_off[ts[7:0]] = apb_req.pwdata[PRS_TOFF_LSB +: TW];
        end
      endcase
    end
    st_d = nx;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp = st_q.rsp;
  assign regulator_enable = st_q.reg_en;
  assign resource_on_bit = st_q.on_bits;
  assign resource_in_transit_bit = st_q.transit_bits;
  assign io_output_enable = st_q.io_enable;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  for (genvar g = 0; g < NRES; g++) begin : g_chk
    property p_timer_settled;
      @(posedge pclk) disable iff (!presetn)
      ((st_q.phase[g] == PRS_ON || st_q.phase[g] == PRS_OFF) == (st_q.timer[g] == '0));
    endproperty
    a_timer_settled: assert property (p_timer_settled)
      else $error("timer and settled state disagree");
    property p_zero_on;
      @(posedge pclk) disable iff (!presetn)
      (go_on[g] && st_q.tick && !shutdown && st_q.t_on[g] == '0) |=> (st_q.phase[g] == PRS_ON);
    endproperty
    a_zero_on: assert property (p_zero_on)
      else $error("zero on time did not switch on at once");
  end

  property p_expiry;
    @(posedge pclk) disable iff (!presetn)
    (st_q.tick && !shutdown && st_q.phase[0] == PRS_RAMP_UP && st_q.timer[0] == TW'(1))
      |=> (st_q.phase[0] == PRS_ON && resource_on_bit[0] && !resource_in_transit_bit[0]);
  endproperty
  a_expiry: assert property (p_expiry)
    else $error("expired ramp-up did not settle on");

  property p_load_on;
    @(posedge pclk) disable iff (!presetn)
    (go_on[0] && st_q.tick && !shutdown && st_q.t_on[0] != '0)
      |=> (st_q.phase[0] == PRS_RAMP_UP && st_q.timer[0] == $past(st_q.t_on[0]));
  endproperty
  a_load_on: assert property (p_load_on)
    else $error("ramp-up timer not loaded with on time");

  property p_hold_between_ticks;
    @(posedge pclk) disable iff (!presetn)
    (!st_q.tick && !shutdown) |=> $stable(st_q.timer);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks)
    else $error("timer moved without a tick");

  property p_keep_needed;
    @(posedge pclk) disable iff (!presetn)
    (st_q.tick && !shutdown && st_q.phase[0] == PRS_ON && need[0])
      |=> (st_q.phase[0] == PRS_ON);
  endproperty
  a_keep_needed: assert property (p_keep_needed)
    else $error("needed resource was switched off");

  property p_core_on;
    @(posedge pclk) disable iff (!presetn)
    (st_q.sync_a[1] || st_q.sync_b[1]) |=> (regulator_enable.core_switching_regulator
      && regulator_enable.core_linear_regulator);
  endproperty
  a_core_on: assert property (p_core_on)
    else $error("core regulators off while a request is high");

  property p_all_off;
    @(posedge pclk) disable iff (!presetn)
    shutdown |=> (regulator_enable == '0 && !io_output_enable && resource_on_bit == '0);
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("shutdown left a regulator or driver on");

  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
    (apb_req.psel && apb_req.penable && !apb_rsp.pready) |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("bus answer not one cycle after access");
endmodule
`default_nettype wire

// ---- dv/prs_core_model.sv ----
// Core model: turns the bench's wish list into clock requests on pclk.
// Assumes the bench changes want right after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module prs_core_model #(
  parameter int unsigned LAG = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Wish and request
  input wire logic [3:0] want,
  output logic [3:0] clock_request
);
  logic [3:0] pipe_q [LAG];
  // Slow cores raise and drop requests some cycles late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LAG; i++) pipe_q[i] <= 4'h0;
    end else begin
      pipe_q[0] <= want;
      for (int i = 1; i < LAG; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign clock_request = pipe_q[LAG-1];
endmodule
`default_nettype wire

// ---- dv/prs_sequencer_test.sv ----
// Self-checking bench of the power resource sequencer.
// Assumes a short tick divider so ramps take only tens of cycles.
`timescale 1ns/10ps
`default_nettype none
module prs_sequencer_test;
  import prs_pkg::*;
  localparam int unsigned TD = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  prs_apb_req_type apb_req = '0;
  prs_apb_rsp_type apb_rsp;
  logic [3:0] want = 4'h0;
  logic [3:0] clock_request;
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  prs_reg_en_type reg_en;
  logic [7:0] on_bits;
  logic [7:0] transit;
  logic io_oe;
  logic [7:0] seen_tr = 8'h00;
  logic [31:0] v;
  int mismatches = 0;
  int tests_run = 0;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) seen_tr <= seen_tr | transit;

  prs_core_model #(.LAG(3)) u_prs_core_model (.pclk(pclk), .presetn(presetn),
    .want(want), .clock_request(clock_request));
  prs_sequencer #(.TICK_DIV(TD)) u_prs_sequencer (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .clock_request(clock_request),
    .radio_a_power_request(pin_a), .radio_b_power_request(pin_b),
    .regulator_enable(reg_en), .resource_on_bit(on_bits),
    .resource_in_transit_bit(transit), .io_output_enable(io_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One idle edge after each transfer keeps requests from colliding
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic wait_on(input logic [7:0] m);
    int n;
    n = 0;
    while (on_bits !== m && n < 600) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 600) mismatches++;
  endtask

  task automatic wait_tr(input int i);
    int n;
    n = 0;
    while (transit[i] !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) mismatches++;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up;
    int n;
    check(io_oe, 1'b0);
    pin_a <= 1'b1;
    wait_tr(0);
    check(on_bits, 8'h00);
    n = 0;
    while (on_bits[0] !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(n, 2 * TD);
    check(transit, 8'h00);
    check(reg_en, 5'h18);
    check(io_oe, 1'b1);
    $display("power up done");
  endtask

  task automatic t_clocks;
    wr(PRS_TIME_OFS + 12'h00c, 32'h0);
    want <= 4'h8;
    wait_tr(2);
    check(transit, 8'h04);
    check(on_bits, 8'h03);
    wait_on(8'h0f);
    check(on_bits, 8'h0f);
    want <= 4'h0;
    wait_tr(2);
    check(transit, 8'h04);
    check(on_bits, 8'h07);
    wait_on(8'h01);
    check(on_bits, 8'h01);
    check(seen_tr[3], 1'b0);
    $display("clock requests done");
  endtask

  task automatic t_demand;
    logic e;
    wr(PRS_REGCTL_OFS, 32'h5);
    rd(PRS_REGSTAT_OFS, v);
    check(v, 32'h1d);
    check(reg_en, 5'h1d);
    apb(1'b0, 12'h018, 32'h0, v, e);
    check({v[30:0], e}, 32'h1);
    $display("demand done");
  endtask

  task automatic t_shutdown;
    pin_a <= 1'b0;
    repeat (6) @(posedge pclk);
    check(reg_en, 5'h00);
    check(io_oe, 1'b0);
    check(on_bits, 8'h00);
    pin_b <= 1'b1;
    repeat (6) @(posedge pclk);
    check(reg_en, 5'h18);
    rd(PRS_TIME_OFS + 12'h00c, v);
    check(v, 32'h0001_0002);
    wait_on(8'h01);
    wr(PRS_RTMR_OFS, 32'h000a_0002);
    wait_on(8'h03);
    check(on_bits, 8'h03);
    wait_on(8'h01);
    check(on_bits, 8'h01);
    $display("shutdown done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(PRS_MIN_OFS, v);
    check(v, 32'h1);
    t_power_up();
    t_clocks();
    t_demand();
    t_shutdown();
    complete_run();
  end

  // Whole run is under a thousand cycles; this leaves a wide margin
  initial begin
    #(40_000 * 5);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
